/* File: pkg/tcc_pkg.sv */
// constants shared by the capture/compare pair and its bench
package tcc_pkg;
	// ----------------------------------------
	// register byte offsets on the APB
	// ----------------------------------------
	localparam logic [7:0] OFS_CCA = 8'h00;
	localparam logic [7:0] OFS_CCB = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_PRM = 8'h0C;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_CNT = 8'h14;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CAP_SEL_A_BIT = 0;
	localparam int CAP_SOURCE_A_BIT = 1;
	localparam int CAP_SEL_B_BIT = 2;
	localparam int PIN_OUT_BIT = 3;
	localparam int EDGE_A_LO_BIT = 4;
	localparam int EDGE_B_LO_BIT = 6;
	localparam int ONE_SHOT_BIT = 2;
	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
	localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
	localparam logic [15:0] CC_RESET = 16'h0000;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] EDGE_RESET = 4'h0;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [1:0] STRB_HALF = 2'h3;
endpackage

/* File: rtl/timer_capture_compare_pair.sv */
// two 16-bit capture/compare registers on a 16-bit up-counter, APB slave
`timescale 1ns/1ps
// Behaviour
// - compare mode: register a compared to counter, match raises irq a, value held
// - control bit 0 selects capture for a; bit 1 picks input a (1) or b (0)
// - input a capturing into a uses opposite edge; field 11 means no capture
// - input b capturing into a: 00 falling, 01 rising, 11 both edges
// - prescaler mode bits 7:6 edge field of input b, bits 5:4 of input a
// - zero in a: irq a fires as counter steps 0000 to 0001 after wrap
// - zero in a: irq a also follows match, edge or one-shot clear
// - pin serving as input b never drives the timer output, and vice versa
// - read colliding with capture may return junk; captured value stays right
// - stop colliding with capture gives an unpredictable captured value
// - control bit 2 selects capture or compare for register b
// - compare mode: register b compared to counter, match raises irq b, value held
// - b captures on input a edges: 00 falling, 01 rising, 11 both
// - zero in b: irq b at 0000 to 0001 step and after any clear
// - writes to b while counting are accepted at once
// - reset clears both registers; each is written as one 16-bit access
// - control bit 0 decides capture or compare for register a
// - counter increments on each rising edge of CLK_I unless stopped or cleared
// - capture into a raises irq a
module timer_capture_compare_pair
	import tcc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	input wire logic TIMER_INPUT_A_I,
	input wire logic PIN_B_I,
	output logic PIN_B_O,
	output logic PIN_B_OE_O,
	output logic MATCH_IRQ_A_O,
	output logic MATCH_IRQ_B_O
);

	// ----------------------------------------
	// edge field decode
	// ----------------------------------------
	// 10 is never programmed, so it simply yields no event
	function automatic logic edge_hit(input logic [1:0] fld, input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		unique case (fld)
			EDGE_FALL: hit = fall;
			EDGE_RISE: hit = rise;
			EDGE_BOTH: hit = rise | fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [15:0] cca_q, cca_d;
	logic [15:0] ccb_q, ccb_d;
	logic [3:0] ctrl_q, ctrl_d;
	logic [3:0] edge_q, edge_d;
	logic [1:0] mode_q, mode_d;
	logic [15:0] cnt_q, cnt_d;
	logic [2:0] sync_a_q, sync_a_d;
	logic [2:0] sync_b_q, sync_b_d;
	logic irq_a_q, irq_a_d;
	logic irq_b_q, irq_b_d;
	logic tout_q, tout_d;
	logic [31:0] prdata_q, prdata_d;
	logic slverr_q, slverr_d;
	logic ready_q;

	// ----------------------------------------
	// decode of fields and bus phases
	// ----------------------------------------
	logic cap_sel_a, cap_source_a, cap_sel_b, pin_out;
	logic [1:0] edge_a, edge_b;
	logic setup, wr_acc, full_half, addr_ok;
	logic rise_a, fall_a, rise_b, fall_b;
	logic valid_a, cap_a, cap_b, running;
	logic match_a, match_b, one_shot, clr_cnt;

	assign cap_sel_a = ctrl_q[CAP_SEL_A_BIT];
	assign cap_source_a = ctrl_q[CAP_SOURCE_A_BIT];
	assign cap_sel_b = ctrl_q[CAP_SEL_B_BIT];
	assign pin_out = ctrl_q[PIN_OUT_BIT];
	assign edge_a = edge_q[1:0];
	assign edge_b = edge_q[3:2];
	assign setup = PSEL_I & ~PENABLE_I;
	assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
	assign full_half = (PSTRB_I[1:0] == STRB_HALF);
	assign addr_ok = (PADDR_I == OFS_CCA) | (PADDR_I == OFS_CCB) | (PADDR_I == OFS_CTRL)
		| (PADDR_I == OFS_PRM) | (PADDR_I == OFS_MODE) | (PADDR_I == OFS_CNT);

	// edge detect reads only the second and third stages
	assign rise_a = sync_a_q[1] & ~sync_a_q[2];
	assign fall_a = ~sync_a_q[1] & sync_a_q[2];
	// while the shared pin drives the timer output its level is no input event
	assign rise_b = ~pin_out & sync_b_q[1] & ~sync_b_q[2];
	assign fall_b = ~pin_out & ~sync_b_q[1] & sync_b_q[2];

	assign valid_a = edge_hit(edge_a, rise_a, fall_a);

	// capture into a: input a on its opposite edge, input b on its own edge
	always_comb begin
		cap_a = 1'b0;
		if (cap_sel_a) begin
			if (cap_source_a) begin
				unique case (edge_a)
					EDGE_RISE: cap_a = fall_a;
					EDGE_FALL: cap_a = rise_a;
					default: cap_a = 1'b0;
				endcase
			end else begin
				cap_a = edge_hit(edge_b, rise_b, fall_b);
			end
		end
	end

	assign cap_b = cap_sel_b & valid_a;
	assign running = (mode_q != MODE_STOP);
	// a match is taken as the counter leaves the value, so a zero register
	// fires on the 0000 to 0001 step whether that follows a wrap or a clear
	assign match_a = running & ~cap_sel_a & (cnt_q == cca_q);
	assign match_b = running & ~cap_sel_b & (cnt_q == ccb_q);
	assign one_shot = wr_acc & (PADDR_I == OFS_MODE) & PWDATA_I[ONE_SHOT_BIT];
	assign clr_cnt = one_shot
		| ((mode_q == MODE_CLR_EDGE) & valid_a)
		| ((mode_q == MODE_CLR_MATCH) & match_a);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// stop mode holds the counter at zero
	always_comb begin
		cnt_d = cnt_q;
		if (!running) begin
			cnt_d = CNT_RESET;
		end else if (clr_cnt) begin
			cnt_d = CNT_RESET;
		end else begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	always_comb begin
		sync_a_d = {sync_a_q[1:0], TIMER_INPUT_A_I};
		sync_b_d = {sync_b_q[1:0], PIN_B_I};
	end

	// ----------------------------------------
	// capture/compare registers
	// ----------------------------------------
	// capture beats a software write in the same cycle; the write is lost,
	// which only happens when software ignores the running counter
	always_comb begin
		cca_d = cca_q;
		ccb_d = ccb_q;
		if (cap_a) begin
			cca_d = cnt_q;
		end else if (wr_acc && PADDR_I == OFS_CCA && full_half) begin
			cca_d = PWDATA_I[15:0];
		end
		if (cap_b) begin
			ccb_d = cnt_q;
		end else if (wr_acc && PADDR_I == OFS_CCB && full_half) begin
			ccb_d = PWDATA_I[15:0];
		end
	end

	// ----------------------------------------
	// control, edge and mode registers
	// ----------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		edge_d = edge_q;
		mode_d = mode_q;
		if (wr_acc && PSTRB_I[0]) begin
			if (PADDR_I == OFS_CTRL) begin
				ctrl_d = PWDATA_I[3:0];
			end
			if (PADDR_I == OFS_PRM) begin
				edge_d = PWDATA_I[7:EDGE_A_LO_BIT];
			end
			if (PADDR_I == OFS_MODE) begin
				mode_d = PWDATA_I[1:0];
			end
		end
	end

	// ----------------------------------------
	// interrupts and timer output
	// ----------------------------------------
	always_comb begin
		irq_a_d = match_a | cap_a;
		irq_b_d = match_b;
		tout_d = tout_q;
		if (!running) begin
			tout_d = 1'b0;
		end else if (match_a | match_b) begin
			tout_d = ~tout_q;
		end
	end

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	// read data is built in the setup cycle so it leaves a flop; a read that
	// meets a capture returns the old value, the capture still lands
	always_comb begin
		prdata_d = prdata_q;
		slverr_d = slverr_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			slverr_d = ~addr_ok;
			if (!PWRITE_I) begin
				unique case (PADDR_I)
					OFS_CCA: prdata_d[15:0] = cca_q;
					OFS_CCB: prdata_d[15:0] = ccb_q;
					OFS_CTRL: prdata_d[3:0] = ctrl_q;
					OFS_PRM: prdata_d[7:EDGE_A_LO_BIT] = edge_q;
					OFS_MODE: prdata_d[1:0] = mode_q;
					OFS_CNT: prdata_d[15:0] = cnt_q;
					default: prdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cca_q <= CC_RESET;
			ccb_q <= CC_RESET;
			ctrl_q <= CTRL_RESET;
			edge_q <= EDGE_RESET;
			mode_q <= MODE_RESET;
			cnt_q <= CNT_RESET;
			sync_a_q <= 3'h0;
			sync_b_q <= 3'h0;
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			tout_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			cca_q <= cca_d;
			ccb_q <= ccb_d;
			ctrl_q <= ctrl_d;
			edge_q <= edge_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			sync_a_q <= sync_a_d;
			sync_b_q <= sync_b_d;
			irq_a_q <= irq_a_d;
			irq_b_q <= irq_b_d;
			tout_q <= tout_d;
			prdata_q <= prdata_d;
			slverr_q <= slverr_d;
			ready_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs, all from flops
	// ----------------------------------------
	assign PREADY_O = ready_q;
	assign PRDATA_O = prdata_q;
	assign PSLVERR_O = slverr_q;
	assign MATCH_IRQ_A_O = irq_a_q;
	assign MATCH_IRQ_B_O = irq_b_q;
	assign PIN_B_O = tout_q;
	assign PIN_B_OE_O = ctrl_q[PIN_OUT_BIT];

endmodule // timer_capture_compare_pair

/* File: verification/timer_capture_compare_pair_props.sv */
// port assertions for the capture/compare pair
`timescale 1ns/1ps
module tcc_props
	import tcc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic PREADY_O,
	input wire logic [31:0] PRDATA_O,
	input wire logic PSLVERR_O,
	input wire logic PIN_B_O,
	input wire logic PIN_B_OE_O,
	input wire logic MATCH_IRQ_A_O,
	input wire logic MATCH_IRQ_B_O
);
	// ----
	// decoded bus events
	// ----
	// plain nets, so that $past always sees a single signal
	wire logic setup = PSEL_I && !PENABLE_I;
	wire logic acc = PSEL_I && PENABLE_I;
	wire logic wr0 = acc && PWRITE_I && PSTRB_I[0];
	wire logic ctl_wr = wr0 && PADDR_I == OFS_CTRL;
	wire logic stop_wr = wr0 && PADDR_I == OFS_MODE && PWDATA_I[1:0] == MODE_STOP;
	wire logic oe_bit = PWDATA_I[PIN_OUT_BIT];
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	// ----
	// checks
	// ----
	a_ready_after_reset: assert property ($rose(NRST_I) |=> PREADY_O)
		else $error("ready low");
	a_err_on_unmapped: assert property (setup && PADDR_I[1:0] == 2'h0 |=>
		PSLVERR_O == ($past(PADDR_I) > OFS_CNT)) else $error("bad slave error");
	a_upper_half_zero: assert property (acc && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000)
		else $error("upper bits set");
	a_read_data_holds: assert property (setup ##1 acc |=> $stable(PRDATA_O))
		else $error("read data moved");
	a_oe_follows_ctrl: assert property (ctl_wr |=> PIN_B_OE_O == $past(oe_bit))
		else $error("enable not loaded");
	a_oe_holds_still: assert property (!ctl_wr |=> $stable(PIN_B_OE_O))
		else $error("enable moved");
	a_stop_quiets_pin: assert property (stop_wr |-> ##2 (!PIN_B_O && !MATCH_IRQ_B_O))
		else $error("active while stopped");
	a_irq_b_single: assert property (MATCH_IRQ_B_O |=> !MATCH_IRQ_B_O)
		else $error("long match pulse");
	// main scenarios reached
	c_irq_a: cover property (MATCH_IRQ_A_O);
	c_irq_b: cover property (MATCH_IRQ_B_O);
	c_err: cover property (acc && PSLVERR_O);
endmodule // tcc_props

bind timer_capture_compare_pair tcc_props i_props (.CLK_I, .NRST_I, .PSEL_I, .PENABLE_I,
	.PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I, .PREADY_O, .PRDATA_O, .PSLVERR_O,
	.PIN_B_O, .PIN_B_OE_O, .MATCH_IRQ_A_O, .MATCH_IRQ_B_O);

/* File: verification/pulse_pins.sv */
// far side: two pulse pins, the second shared with the timer output
`timescale 1ns/1ps
module pulse_pins (
	input wire logic lvl_a_i,
	input wire logic lvl_b_i,
	input wire logic oe_i,
	input wire logic out_i,
	output logic pin_a_o,
	output logic pin_b_o
);
	// ----
	// pin levels
	// ----
	// pin a is a plain pulse source
	assign pin_a_o = lvl_a_i;
	// the shared pin follows the block while it drives, so no two drivers fight
	assign pin_b_o = oe_i ? out_i : lvl_b_i;
endmodule // pulse_pins

/* File: verification/timer_capture_compare_pair_tb.sv */
// self-checking bench for the capture/compare pair
`timescale 1ns/1ps
module timer_capture_compare_pair_tb;
	import tcc_pkg::*;
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, la = 0, lb = 0;
	logic [7:0] padr = 8'h00;
	logic [3:0] pstb = 4'hF;
	logic [7:0] ra;
	logic [31:0] pwd = 32'h0, prd, rq, ia = 0, ib = 0, ia0, ib0;
	logic [3:0] ctl [10] = '{4'h3, 4'h3, 4'h3, 4'h1, 4'h1, 4'h1, 4'h4, 4'h4, 4'h4, 4'h9};
	logic [1:0] want_edges [10] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};
	logic [1:0] code [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
	logic [1:0] got;
	logic [15:0] prev;
	logic rdy, err, re, pa, pb, po, poe, iqa, iqb;
	int fail_count = 0, comparisons = 0;
	// ----
	// clock, design and far side
	// ----
	always #4 clk = ~clk;
	timer_capture_compare_pair i_dut (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(pstb),
		.PREADY_O(rdy), .PRDATA_O(prd), .PSLVERR_O(err), .TIMER_INPUT_A_I(pa),
		.PIN_B_I(pb), .PIN_B_O(po), .PIN_B_OE_O(poe), .MATCH_IRQ_A_O(iqa),
		.MATCH_IRQ_B_O(iqb));
	pulse_pins i_pins (.lvl_a_i(la), .lvl_b_i(lb), .oe_i(poe), .out_i(po),
		.pin_a_o(pa), .pin_b_o(pb));
	// count interrupt pulses so tests compare totals, not exact cycles
	always @(posedge clk) begin
		if (iqa === 1'b1) ia <= ia + 1;
		if (iqb === 1'b1) ib <= ib + 1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, seen, want);
		end
	endtask
	// one transfer held until ready is sampled, then an idle cycle;
	// only the watchdog ends a wait for ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rq = prd;
		re = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		apb(1'b0, a, 32'h0);
		check(rq, want);
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog: the sequence needs under 700 cycles, allow twenty thousand
	initial begin
		#160000;
		fail_count++;
		complete_run();
	end
	// ----
	// test sequence
	// ----
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(OFS_CCA, 32'h0);
		rd(OFS_CCB, 32'h0);
		// a write that covers only the low byte must leave the register alone
		pstb <= 4'h1;
		wr(OFS_CCA, 32'h1234);
		pstb <= 4'hF;
		rd(OFS_CCA, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(32'(re), 32'h1);
		wr(OFS_MODE, 32'(MODE_FREE));
		repeat (10) @(posedge clk);
		check(ia, 32'h1);
		check(ib, 32'h1);
		$display("test zero registers done");
		wr(OFS_MODE, 32'h0);
		wr(OFS_CCA, 32'h10);
		wr(OFS_CCB, 32'h8);
		ia0 = ia;
		ib0 = ib;
		wr(OFS_MODE, 32'(MODE_FREE));
		repeat (40) @(posedge clk);
		wr(OFS_CCB, 32'h80);
		repeat (100) @(posedge clk);
		check(ia - ia0, 32'h1);
		check(ib - ib0, 32'h2);
		rd(OFS_CCA, 32'h10);
		rd(OFS_CCB, 32'h80);
		wr(OFS_MODE, 32'h0);
		ia0 = ia;
		wr(OFS_MODE, 32'(MODE_CLR_MATCH));
		repeat (45) @(posedge clk);
		check(ia - ia0, 32'h2);
		$display("test compare done");
		// each setting: rising then falling edge, a changed register means a capture
		for (int k = 0; k < 10; k++) begin
			ra = ctl[k][CAP_SEL_B_BIT] ? OFS_CCB : OFS_CCA;
			wr(OFS_MODE, 32'h0);
			wr(ra, 32'h0);
			wr(OFS_CTRL, 32'(ctl[k]));
			wr(OFS_PRM, {24'h0, code[k % 3], code[k % 3], 4'h0});
			wr(OFS_MODE, 32'(MODE_FREE));
			ia0 = ia;
			prev = 16'h0;
			for (int e = 0; e < 2; e++) begin
				if (ctl[k][2:1] == 2'h0)
					lb <= (e == 0);
				else
					la <= (e == 0);
				repeat (8) @(posedge clk);
				apb(1'b0, ra, 32'h0);
				got[1 - e] = rq[15:0] !== prev;
				prev = rq[15:0];
			end
			check(32'(got), 32'(want_edges[k]));
			if (ctl[k][0])
				check(ia - ia0, 32'(got[1]) + 32'(got[0]));
		end
		$display("test capture done");
		// zero registers fire again after an edge clear and after a one-shot clear
		wr(OFS_MODE, 32'h0);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CCA, 32'h0);
		wr(OFS_CCB, 32'h0);
		wr(OFS_PRM, {24'h0, EDGE_RISE, EDGE_RISE, 4'h0});
		wr(OFS_MODE, 32'(MODE_CLR_EDGE));
		repeat (20) @(posedge clk);
		ia0 = ia;
		ib0 = ib;
		la <= 1'b1;
		repeat (8) @(posedge clk);
		check(ia - ia0, 32'h1);
		check(ib - ib0, 32'h1);
		ia0 = ia;
		ib0 = ib;
		wr(OFS_MODE, 32'(MODE_FREE) | (32'h1 << ONE_SHOT_BIT));
		repeat (8) @(posedge clk);
		check(ia - ia0, 32'h1);
		check(ib - ib0, 32'h1);
		$display("test clear events done");
		complete_run();
	end
endmodule // timer_capture_compare_pair_tb
